/* File: bench/smmct_ctrl_assertions.sv */
// port-level assertions for the management control block
// assumes a bind from tb and the single CLK domain
`timescale 1ns/1ps
module smmct_chk
  import smmct_pkg::*;
#(
  parameter int STS_A_W = 7,
  parameter int STS_B_W = 8,
  parameter int TIMERS  = 5
)(
  input wire logic               CLK,
  input wire logic               RST_B,
  input wire smmct_req_s         REQ,
  input wire logic [7:0]         RDATA,
  input wire logic [STS_A_W-1:0] STS_A,
  input wire logic [STS_B_W-1:0] STS_B,
  input wire logic [TIMERS-1:0]  TMR_FLAG,
  input wire logic [STS_A_W-1:0] BRK_SET_A,
  input wire logic               RD_STS_A,
  input wire logic [19:0]        CPU_ADDR,
  input wire logic [19:0]        MEM_ADDR,
  input wire logic               MGMT_MODE_ENABLE,
  input wire logic               MGMT_INTERRUPT_N,
  input wire logic               MGMT_ADDR_STROBE_N,
  input wire logic               KEYSWITCH_IN,
  input wire logic               SPEED_SELECT_IN
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a plain read of the control register
  sequence s_rd; REQ.rd && !REQ.wr && REQ.index == 8'h18; endsequence
  property p_en; s_rd |=> RDATA[7] == $past(MGMT_MODE_ENABLE); endproperty
  a_en: assert property (p_en) else $error("enable readback");
  // reset must not be masked by its own disable
  property p_rst; disable iff (1'b0) !RST_B |=> !MGMT_MODE_ENABLE; endproperty
  a_rst: assert property (p_rst) else $error("enable reset");
  property p_pin; !MGMT_MODE_ENABLE |-> MGMT_INTERRUPT_N && MGMT_ADDR_STROBE_N;
  endproperty
  a_pin: assert property (p_pin) else $error("pins not muxed");
  property p_key; MGMT_MODE_ENABLE |-> !KEYSWITCH_IN && !SPEED_SELECT_IN;
  endproperty
  a_key: assert property (p_key) else $error("keyswitch leaks");
  property p_brk; s_rd |=> RDATA[6] == $past(|STS_A || |STS_B || |TMR_FLAG);
  endproperty
  a_brk: assert property (p_brk) else $error("break flag");
  property p_clr; RD_STS_A && BRK_SET_A == '0 |=> STS_A == '0; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_act; s_rd |=> RDATA[3] == !$past(MGMT_INTERRUPT_N); endproperty
  a_act: assert property (p_act) else $error("active bit");
  // outside the 60000h window the address passes untouched
  property p_thru; CPU_ADDR[19:16] != 4'h6 |=> MEM_ADDR == $past(CPU_ADDR);
  endproperty
  a_thru: assert property (p_thru) else $error("address changed");
endmodule

/* File: bench/smmct_host.sv */
// host processor model driving the shared interrupt and strobe pins
// assumes the bench asks for management entry and exit
`timescale 1ns/1ps
module smmct_host (
  input  wire logic clk,
  input  wire logic smi_req,
  input  wire logic en_seen,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end
  // no interrupt before enable is set, which would hang the cpu
  always @(posedge clk) begin
    pin_a <= !(smi_req && en_seen);
  end
  // strobe pulses every other cycle while in management mode
  always @(posedge clk) begin
    pin_b <= pin_a ? 1'b1 : !pin_b;
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the management control block
// assumes the host model drives the shared pins
`timescale 1ns/1ps
module tb;
  import smmct_pkg::*;
  logic CLK, RST_B, smi, pa, pb, rs_a, men, mtr, bwa;
  logic [6:0]  bs_a;
  logic [7:0]  rdat;
  logic [19:0] ca, ma;
  smmct_req_s  rq;
  int n_errors, checked, seed, en, opt, lock, sel, brk, off;
  int bases[7] = '{'hE8000, 'hA0000, 'hB0000, 'hC8000, 'hA0000, 'hB0000,
                   'hB0000};
  smmct_ctrl dut_u (.CLK(CLK), .RST_B(RST_B), .REQ(rq), .RDATA(rdat),
    .PIN_SHARED_A(pa), .PIN_SHARED_B(pb), .BRK_SET_A(bs_a),
    .BRK_SET_B(8'h00), .TMR_SET(5'h00), .RD_STS_A(rs_a), .RD_STS_B(1'b0),
    .RD_TMR(5'h00), .STS_A(), .STS_B(), .TMR_FLAG(), .BRK_WR_ALLOW(bwa),
    .CPU_ADDR(ca), .MEM_ADDR(ma), .MEM_TO_REGION(mtr),
    .MGMT_MODE_ENABLE(men),
    .MGMT_INTERRUPT_N(), .MGMT_ADDR_STROBE_N(), .KEYSWITCH_IN(),
    .SPEED_SELECT_IN());
  smmct_host host_u (.clk(CLK), .smi_req(smi), .en_seen(men), .pin_a(pa),
    .pin_b(pb));
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(logic [19:0] got, logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // model keeps the write lock: state before the write decides
  task automatic wr(logic [7:0] d);
    @(negedge CLK);
    rq = '{1'b1, 1'b0, 8'h18, d};
    if (lock == 0 || (en != 0 && smi)) begin
      en = d[7];
      opt = d[5];
      lock = d[4];
      sel = d[2:0];
    end
    @(negedge CLK);
    rq = '0;
  endtask
  task automatic rd();
    @(negedge CLK);
    rq = '{1'b0, 1'b1, 8'h18, 8'h00};
    @(negedge CLK);
    rq = '0;
    chk({12'h0, rdat}, {12'h0, en[0], brk[0], opt[0], lock[0], en[0] & smi,
        sel[2:0]});
    chk({19'h0, bwa}, {19'h0, lock == 0 || (en != 0 && smi)});
  endtask
  // m is whether the access should land in the management region
  task automatic tr(logic [19:0] a, logic [19:0] e, logic m);
    @(negedge CLK);
    ca = a;
    @(negedge CLK);
    chk(ma, e);
    chk({19'h0, mtr}, {19'h0, m});
  endtask
  // host register plus two sync stages settle within five cycles
  task automatic pin(logic v);
    smi = v;
    repeat (5) @(negedge CLK);
  endtask
  initial begin
    CLK = 0;
    forever #20 CLK = ~CLK;
  end
  // watchdog so a hang still reaches the verdict
  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    end_sim();
  end
  initial begin
    seed = 32'habd1;
    rq = '0; ca = '0; smi = 0; bs_a = '0; rs_a = 0;
    en = 0; opt = 1; lock = 0; sel = 0; brk = 0;
    RST_B = 0;
    repeat (6) @(negedge CLK);
    RST_B = 1;
    rd();
    wr(8'hA0);
    pin(1);
    for (int c = 0; c < 7; c++) begin
      off = $random(seed) & (c < 4 ? 'h7FFF : 'hFFFF);
      wr({5'b10100, c[2:0]});
      rd();
      tr(20'h60000 + off[19:0], bases[c][19:0] + off[19:0], 1'b1);
      tr(20'h23456, 20'h23456, 1'b0);
    end
    // option clear: window address passes untranslated, region C8000h reached directly
    wr(8'h83);
    tr(20'h61234, 20'h61234, 1'b0);
    tr(20'hC9234, 20'hC9234, 1'b1);
    pin(0);
    @(negedge CLK);
    bs_a = 7'h04;
    @(negedge CLK);
    bs_a = '0;
    brk = 1;
    wr(8'hC3);
    rd();
    @(negedge CLK);
    rs_a = 1;
    @(negedge CLK);
    rs_a = 0;
    brk = 0;
    rd();
    wr(8'h90);
    wr(8'h93);
    rd();
    pin(1);
    wr(8'h93);
    rd();
    end_sim();
  end
endmodule
bind smmct_ctrl smmct_chk #(.STS_A_W(STS_A_W), .STS_B_W(STS_B_W),
  .TIMERS(TIMERS)) chk_u (.CLK(CLK), .RST_B(RST_B), .REQ(REQ),
  .RDATA(RDATA), .STS_A(STS_A), .STS_B(STS_B), .TMR_FLAG(TMR_FLAG),
  .BRK_SET_A(BRK_SET_A), .RD_STS_A(RD_STS_A), .CPU_ADDR(CPU_ADDR),
  .MEM_ADDR(MEM_ADDR), .MGMT_MODE_ENABLE(MGMT_MODE_ENABLE),
  .MGMT_INTERRUPT_N(MGMT_INTERRUPT_N),
  .MGMT_ADDR_STROBE_N(MGMT_ADDR_STROBE_N), .KEYSWITCH_IN(KEYSWITCH_IN),
  .SPEED_SELECT_IN(SPEED_SELECT_IN));

/* File: rtl/smmct_ctrl.sv */
// management mode control register with address translation
// assumes config port requests and break sources are on CLK;
// pins arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - enable bit 7 turns on management features; resets to zero.
// - enable selects interrupt/strobe pin use, else keyswitch and speed.
// - break flag bit 6 is OR of break status and timer bits.
// - reading break status or timer registers clears them; the flag clears once all are clear.
// - option, enable and active all set redirect the 60000h window, except with code 111.
// - option clear suspends translation; region reachable directly.
// - rest of space below 1MB is never translated.
// - with lock set, writes accepted only while interrupt active.
// - with lock clear, writes always accepted; lock resets to zero.
// - bit 3 reads the inverse of the active-low interrupt pin.
// - codes 000-011 select 32K at E8000h, A0000h, B0000h, C8000h.
// - codes 100 and 101/110 select 64K at A0000h and B0000h.
`timescale 1ns/1ps
module smmct_ctrl
  import smmct_pkg::*;
#(
  parameter int STS_A_W = 7,
  parameter int STS_B_W = 8,
  parameter int TIMERS  = 5
)(
  input  wire logic               CLK,
  input  wire logic               RST_B,
  input  wire smmct_req_s         REQ,
  output logic [7:0]              RDATA,
  input  wire logic               PIN_SHARED_A,
  input  wire logic               PIN_SHARED_B,
  input  wire logic [STS_A_W-1:0] BRK_SET_A,
  input  wire logic [STS_B_W-1:0] BRK_SET_B,
  input  wire logic [TIMERS-1:0]  TMR_SET,
  input  wire logic               RD_STS_A,
  input  wire logic               RD_STS_B,
  input  wire logic [TIMERS-1:0]  RD_TMR,
  output logic [STS_A_W-1:0]      STS_A,
  output logic [STS_B_W-1:0]      STS_B,
  output logic [TIMERS-1:0]       TMR_FLAG,
  output logic                    BRK_WR_ALLOW,
  input  wire logic [19:0]        CPU_ADDR,
  output logic [19:0]             MEM_ADDR,
  output logic                    MEM_TO_REGION,
  output logic                    MGMT_MODE_ENABLE,
  output logic                    MGMT_INTERRUPT_N,
  output logic                    MGMT_ADDR_STROBE_N,
  output logic                    KEYSWITCH_IN,
  output logic                    SPEED_SELECT_IN
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;

  // two flops; only the second stage is read
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
    end else begin
      sync1_reg <= {PIN_SHARED_B, PIN_SHARED_A};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // control register fields
  // ****************************************
  logic                   enable_reg;
  logic                   option_reg;
  logic                   lock_reg;
  logic [SMMCT_SEL_W-1:0] sel_reg;
  logic                   active;
  logic                   brk_flag;
  logic                   ctrl_wr;
  logic                   wr_allow;

  // interrupt pin is only meaningful as such when enabled
  assign active   = enable_reg & ~sync2_reg[0];
  assign wr_allow = ~lock_reg | active;
  assign ctrl_wr  = REQ.wr & (REQ.index == SMMCT_CTRL_INDEX)
                    & wr_allow;
  assign BRK_WR_ALLOW = wr_allow;

  // only bits 7,5,4 and the select field are writable
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      enable_reg <= SMMCT_CTRL_RESET[SMMCT_EN_BIT];
      option_reg <= SMMCT_CTRL_RESET[SMMCT_OPT_BIT];
      lock_reg   <= SMMCT_CTRL_RESET[SMMCT_LOCK_BIT];
      sel_reg    <= SMMCT_CTRL_RESET[SMMCT_SEL_W-1:0];
    end else if (ctrl_wr) begin
      enable_reg <= REQ.wdata[SMMCT_EN_BIT];
      option_reg <= REQ.wdata[SMMCT_OPT_BIT];
      lock_reg   <= REQ.wdata[SMMCT_LOCK_BIT];
      sel_reg    <= REQ.wdata[SMMCT_SEL_W-1:0];
    end
  end

  // ****************************************
  // break status, cleared on read
  // ****************************************
  // a new event in the read cycle survives the clear
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      STS_A    <= '0;
      STS_B    <= '0;
      TMR_FLAG <= '0;
    end else begin
      STS_A    <= (RD_STS_A ? '0 : STS_A) | BRK_SET_A;
      STS_B    <= (RD_STS_B ? '0 : STS_B) | BRK_SET_B;
      TMR_FLAG <= (TMR_FLAG & ~RD_TMR) | TMR_SET;
    end
  end

  assign brk_flag = |{STS_A, STS_B, TMR_FLAG};

  // ****************************************
  // read data, readable at all times
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (REQ.rd) begin
      if (REQ.index == SMMCT_CTRL_INDEX) begin
        RDATA <= {enable_reg, brk_flag, option_reg, lock_reg,
                  active, sel_reg};
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  // ****************************************
  // pin function selection
  // ****************************************
  // inactive levels shown for the function not currently selected
  always_comb begin
    MGMT_MODE_ENABLE   = enable_reg;
    MGMT_INTERRUPT_N   = enable_reg ? sync2_reg[0] : 1'b1;
    MGMT_ADDR_STROBE_N = enable_reg ? sync2_reg[1] : 1'b1;
    KEYSWITCH_IN       = enable_reg ? 1'b0 : sync2_reg[0];
    SPEED_SELECT_IN    = enable_reg ? 1'b0 : sync2_reg[1];
  end

  // ****************************************
  // address translation
  // ****************************************
  smmct_region_s region;
  logic          in_window;
  logic          in_region;
  logic          xlate;

  smmct_region_dec u_dec (
    .SEL    (sel_reg),
    .REGION (region)
  );

  // window is the size of the selected region
  assign in_window = (CPU_ADDR & ~region.mask) == SMMCT_WIN_BASE;
  assign in_region = (CPU_ADDR & ~region.mask) == region.base;
  assign xlate     = option_reg & enable_reg & active
                     & region.valid & in_window;

  // registered so the memory side sees a clean address
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      MEM_ADDR      <= 20'h00000;
      MEM_TO_REGION <= 1'b0;
    end else if (xlate) begin
      MEM_ADDR      <= region.base | (CPU_ADDR & region.mask);
      MEM_TO_REGION <= 1'b1;
    end else begin
      MEM_ADDR      <= CPU_ADDR;
      MEM_TO_REGION <= ~option_reg & enable_reg & active
                       & region.valid & in_region;
    end
  end

endmodule

/* File: rtl/smmct_pkg.sv */
// package for the management mode control and translation block
// assumes a single 25 MHz clock domain and an indexed config port
package smmct_pkg;

  // ****************************************
  // register map and field positions
  // ****************************************
  localparam logic [7:0] SMMCT_CTRL_INDEX   = 8'h18;
  localparam logic [7:0] SMMCT_CTRL_RESET   = 8'h20;
  localparam int         SMMCT_EN_BIT       = 7;
  localparam int         SMMCT_BRK_BIT      = 6;
  localparam int         SMMCT_OPT_BIT      = 5;
  localparam int         SMMCT_LOCK_BIT     = 4;
  localparam int         SMMCT_ACT_BIT      = 3;
  localparam int         SMMCT_SEL_W        = 3;

  // ****************************************
  // address constants (20-bit real-mode space)
  // ****************************************
  localparam logic [19:0] SMMCT_WIN_BASE    = 20'h60000;
  localparam logic [19:0] SMMCT_BASE_E8     = 20'hE8000;
  localparam logic [19:0] SMMCT_BASE_A0     = 20'hA0000;
  localparam logic [19:0] SMMCT_BASE_B0     = 20'hB0000;
  localparam logic [19:0] SMMCT_BASE_C8     = 20'hC8000;
  localparam logic [19:0] SMMCT_MASK_32K    = 20'h07FFF;
  localparam logic [19:0] SMMCT_MASK_64K    = 20'h0FFFF;

  // decoded region
  typedef struct packed {
    logic        valid;
    logic [19:0] base;
    logic [19:0] mask;
  } smmct_region_s;

  // register access request from the config port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } smmct_req_s;

endpackage

/* File: rtl/smmct_region_dec.sv */
// decodes the region select field into base and size
// assumes purely combinational use by the control block
`timescale 1ns/1ps
module smmct_region_dec
  import smmct_pkg::*;
(
  input  wire logic [2:0]    SEL,
  output smmct_region_s      REGION
);

  // ****************************************
  // region table
  // ****************************************
  // 111 is reserved and yields no region, so nothing is translated
  always_comb begin
    REGION = '{valid: 1'b1, base: SMMCT_BASE_E8, mask: SMMCT_MASK_32K};
    unique case (SEL)
      3'h0: REGION.base = SMMCT_BASE_E8;
      3'h1: REGION.base = SMMCT_BASE_A0;
      3'h2: REGION.base = SMMCT_BASE_B0;
      3'h3: REGION.base = SMMCT_BASE_C8;
      3'h4: begin
        REGION.base = SMMCT_BASE_A0;
        REGION.mask = SMMCT_MASK_64K;
      end
      3'h5, 3'h6: begin
        REGION.base = SMMCT_BASE_B0;
        REGION.mask = SMMCT_MASK_64K;
      end
      3'h7: REGION.valid = 1'b0;
    endcase
  end

endmodule
